// ===== inc/txco_pkg.sv
// transmit control options package: states, counts and reset values
// assumes a single 250 MHz system clock
package txco_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_PS = 4000;
   localparam int unsigned DEFER_TIME_NS = 3200000; // 3.2 ms of deferral
   localparam int unsigned DEFER_CYCLES = DEFER_TIME_NS / (CLK_PERIOD_PS / 1000); // 800000
   // ****************************************
   // frame layout
   // ****************************************
   localparam logic [2:0] PREAMBLE_LAST = 3'h6; // seven preamble bytes
   localparam logic [2:0] FCS_LAST = 3'h3; // four check bytes
   localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
   localparam logic [7:0] SFD_BYTE = 8'hd5;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam int unsigned FIFO_DEPTH = 4;
   localparam int unsigned DATA_W = 8;
   typedef enum logic [2:0] {
      TXCO_IDLE, TXCO_PRE, TXCO_SFD, TXCO_DATA, TXCO_FCS, TXCO_DROP
   } txco_state_t;
endpackage

// ===== hdl/txco_top.sv
// transmit control options: descriptor options, fcs append, deferral and fifo
// assumes descriptor fetch strobe and byte stream come from logic on mclk
// Behaviour
// [R01] programmed interrupt flag in a fetched descriptor raises status at once
// [R02] software clears the programmed interrupt bit before setting it again
// [R03] software sets the flag at most every second descriptor
// [R04] option 0 starts collision timer after sfd, 1 at first preamble bit
// [R05] checksum inhibit 0 appends four check bytes, 1 omits them
// [R06] deferral timer disable 0 enables the deferral timer, 1 disables it; code at 1 still counts and flags, only skips the abort
// [R07] deferring for 3.2 ms flags excessive deferral, aborts when timer enabled
// [R08] programmed interrupt status stays set until software acknowledges it
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// fifo
// ****************************************
module txco_fifo
   import txco_pkg::*;
#(
   parameter int W = 9,
   parameter int D = 4
)(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   logic [W-1:0] mem_ff [D];
   logic [AW-1:0] wr_ff, rd_ff;
   logic [AW:0] cnt_ff;
   wire do_wr = in_valid && in_ready;
   wire do_rd = out_valid && out_ready;
   // full and empty from the occupancy count
   assign in_ready = (cnt_ff != (AW+1)'(D));
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rd_ff];
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(D-1)) ? '0 : p + 1'b1;
   endfunction
   // pointers, count and storage; no write lands while reset is held
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end
      else
      begin
         if (do_wr) wr_ff <= bump(wr_ff);
         if (do_rd) rd_ff <= bump(rd_ff);
         cnt_ff <= cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
         if (do_wr) mem_ff[wr_ff] <= in_data;
      end
   end
endmodule

// ****************************************
// top
// ****************************************
module txco_top
   import txco_pkg::*;
#(
   parameter int unsigned DEFER_LIMIT = DEFER_CYCLES,
   parameter int DEPTH = FIFO_DEPTH
)(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic desc_fetch,
   input wire logic programmed_tx_interrupt,
   input wire logic late_collision_timer_start,
   input wire logic checksum_inhibit,
   input wire logic deferral_timer_disable,
   input wire logic programmed_tx_interrupt_ack,
   input wire logic [DATA_W-1:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic carrier_sense,
   output logic programmed_tx_interrupt_status,
   output logic excessive_deferral_flag,
   output logic tx_aborted,
   output logic coll_timer_start,
   output logic [DATA_W-1:0] line_data,
   output logic line_valid,
   output logic line_end,
   output logic busy
);
   txco_state_t state_ff, nxt_state;
   logic programmed_tx_interrupt_ff, exd_ff, abort_ff, cts_ff;
   logic crs_meta_ff, crs_ff;
   logic pend_ff, owc_opt_ff, checksum_inhibit_ff, deferral_timer_disable_ff;
   logic [2:0] cnt_ff, nxt_cnt;
   logic [31:0] defer_ff;
   logic [31:0] crc_ff;
   logic [DATA_W-1:0] ld_ff, nxt_ld;
   logic lv_ff, nxt_lv, le_ff, nxt_le, f_valid, f_ready;
   logic [DATA_W:0] f_data;

   txco_fifo #(.W(DATA_W+1), .D(DEPTH)) u_fifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data({tx_last, tx_data}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   // byte-wise crc update, lsb first
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++)
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      crc_byte = r;
   endfunction

   // decode of the frame sequencer
   wire crs_busy = crs_ff;
   wire start_ok = pend_ff && f_valid && !crs_busy;
   wire defer_hit = pend_ff && crs_busy && (defer_ff == DEFER_LIMIT - 1);
   wire do_abort = defer_hit && !deferral_timer_disable_ff; // [R06] [R07]
   wire in_data_st = (state_ff == TXCO_DATA);
   wire in_drop_st = (state_ff == TXCO_DROP);
   assign f_ready = (in_data_st || in_drop_st) && f_valid;
   wire last_pop = f_ready && f_data[DATA_W];
   wire [31:0] crc_out = ~crc_ff;
   wire [7:0] fcs_byte = crc_out[8*cnt_ff[1:0] +: 8];
   wire cts_pre = (state_ff == TXCO_IDLE) && start_ok && owc_opt_ff; // [R04]
   wire cts_sfd = (state_ff == TXCO_SFD) && !owc_opt_ff; // [R04]

   // frame sequencer next state
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_ld = ld_ff;
      nxt_lv = 1'b0;
      nxt_le = 1'b0;
      unique case (state_ff)
         TXCO_IDLE:
         begin
            if (do_abort)
               nxt_state = TXCO_DROP;
            else if (start_ok)
            begin
               nxt_state = TXCO_PRE;
               nxt_cnt = '0;
            end
         end
         TXCO_PRE:
         begin
            nxt_ld = PREAMBLE_BYTE;
            nxt_lv = 1'b1;
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == PREAMBLE_LAST) nxt_state = TXCO_SFD;
         end
         TXCO_SFD:
         begin
            nxt_ld = SFD_BYTE;
            nxt_lv = 1'b1;
            nxt_state = TXCO_DATA;
         end
         TXCO_DATA:
         begin
            if (f_ready)
            begin
               nxt_ld = f_data[DATA_W-1:0];
               nxt_lv = 1'b1;
               if (f_data[DATA_W])
               begin
                  nxt_cnt = '0;
                  nxt_le = checksum_inhibit_ff; // [R05]
                  nxt_state = checksum_inhibit_ff ? TXCO_IDLE : TXCO_FCS; // [R05]
               end
            end
         end
         TXCO_FCS:
         begin
            nxt_ld = fcs_byte; // [R05]
            nxt_lv = 1'b1;
            nxt_cnt = cnt_ff + 3'h1;
            if (cnt_ff == FCS_LAST)
            begin
               nxt_le = 1'b1;
               nxt_state = TXCO_IDLE;
            end
         end
         TXCO_DROP: if (last_pop) nxt_state = TXCO_IDLE; // [R07]
      endcase
   end

   // descriptor options and programmed interrupt status
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         programmed_tx_interrupt_ff <= 1'b0;
         pend_ff <= 1'b0;
         owc_opt_ff <= 1'b0;
         checksum_inhibit_ff <= 1'b0;
         deferral_timer_disable_ff <= 1'b0;
      end
      else
      begin
         // set on fetch wins over acknowledge
         if (desc_fetch && programmed_tx_interrupt)
            programmed_tx_interrupt_ff <= 1'b1; // [R01] [R08]
         else if (programmed_tx_interrupt_ack)
            programmed_tx_interrupt_ff <= 1'b0; // [R08]
         if (desc_fetch)
         begin
            pend_ff <= 1'b1;
            owc_opt_ff <= late_collision_timer_start;
            checksum_inhibit_ff <= checksum_inhibit;
            deferral_timer_disable_ff <= deferral_timer_disable;
         end
         else if ((state_ff == TXCO_IDLE) && (start_ok || do_abort))
            pend_ff <= 1'b0;
      end
   end

   // carrier synchroniser, deferral timer and frame status
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         crs_meta_ff <= 1'b0;
         crs_ff <= 1'b0;
         defer_ff <= '0;
         exd_ff <= 1'b0;
         abort_ff <= 1'b0;
         cts_ff <= 1'b0;
      end
      else
      begin
         crs_meta_ff <= carrier_sense; // only the second stage is read
         crs_ff <= crs_meta_ff;
         if (pend_ff && crs_busy && (state_ff == TXCO_IDLE) && !defer_hit)
            defer_ff <= defer_ff + 32'h1;
         else
            defer_ff <= '0;
         if (defer_hit && (state_ff == TXCO_IDLE))
            exd_ff <= 1'b1; // [R07]
         else if (desc_fetch)
            exd_ff <= 1'b0;
         if ((state_ff == TXCO_IDLE) && do_abort)
            abort_ff <= 1'b1; // [R07]
         else if (desc_fetch)
            abort_ff <= 1'b0;
         cts_ff <= cts_pre || cts_sfd; // [R04]
      end
   end

   // line output and check sequence accumulator
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state_ff <= TXCO_IDLE;
         cnt_ff <= '0;
         ld_ff <= '0;
         lv_ff <= 1'b0;
         le_ff <= 1'b0;
         crc_ff <= CRC_INIT;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         ld_ff <= nxt_ld;
         lv_ff <= nxt_lv;
         le_ff <= nxt_le;
         if (state_ff == TXCO_SFD)
            crc_ff <= CRC_INIT;
         else if (in_data_st && f_ready)
            crc_ff <= crc_byte(crc_ff, f_data[DATA_W-1:0]);
      end
   end

   assign programmed_tx_interrupt_status = programmed_tx_interrupt_ff;
   assign excessive_deferral_flag = exd_ff;
   assign tx_aborted = abort_ff;
   assign coll_timer_start = cts_ff;
   assign line_data = ld_ff;
   assign line_valid = lv_ff;
   assign line_end = le_ff;
   assign busy = (state_ff != TXCO_IDLE) || pend_ff;
endmodule
`default_nettype wire

// ===== dv/txco_sva.sv
// checker: properties on the transmit options top ports
// assumes one mclk domain, synchronous active-low rst_n
`timescale 1ns/10ps
`default_nettype none
module txco_sva
   import txco_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic desc_fetch,
   input wire logic programmed_tx_interrupt,
   input wire logic programmed_tx_interrupt_ack,
   input wire logic programmed_tx_interrupt_status,
   input wire logic coll_timer_start,
   input wire logic [DATA_W-1:0] line_data,
   input wire logic line_valid,
   input wire logic line_end,
   input wire logic tx_aborted,
   input wire logic excessive_deferral_flag
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // interrupt status set, held and cleared
   a_programmed_tx_interrupt_set: assert property (desc_fetch && programmed_tx_interrupt |=> programmed_tx_interrupt_status)
      else $error("status not set by flagged fetch");
   a_programmed_tx_interrupt_hold: assert property (programmed_tx_interrupt_status && !programmed_tx_interrupt_ack |=> programmed_tx_interrupt_status)
      else $error("status lost without ack");
   a_programmed_tx_interrupt_clear: assert property (programmed_tx_interrupt_status && programmed_tx_interrupt_ack
      && !(desc_fetch && programmed_tx_interrupt) |=> !programmed_tx_interrupt_status)
      else $error("status not cleared by ack");
   // timer start pulse and line framing
   a_coll_one: assert property (coll_timer_start |=> !coll_timer_start)
      else $error("timer start longer than a cycle");
   a_coll_sfd: assert property (coll_timer_start && line_valid |-> line_data == SFD_BYTE)
      else $error("timer start beside a non-delimiter byte");
   a_end_valid: assert property (line_end |-> line_valid)
      else $error("frame end without a byte");
   // deferral abort
   a_abort_flag: assert property ($rose(tx_aborted) |-> excessive_deferral_flag)
      else $error("abort without deferral flag");
   a_abort_quiet: assert property (tx_aborted |-> !line_valid)
      else $error("line byte from an aborted frame");
endmodule
bind txco_top txco_sva u_sva (
   .mclk(mclk),
   .rst_n(rst_n),
   .desc_fetch(desc_fetch),
   .programmed_tx_interrupt(programmed_tx_interrupt),
   .programmed_tx_interrupt_ack(programmed_tx_interrupt_ack),
   .programmed_tx_interrupt_status(programmed_tx_interrupt_status),
   .coll_timer_start(coll_timer_start),
   .line_data(line_data),
   .line_valid(line_valid),
   .line_end(line_end),
   .tx_aborted(tx_aborted),
   .excessive_deferral_flag(excessive_deferral_flag)
);
`default_nettype wire

// ===== dv/txco_line_model.sv
// line side model: medium carrier, byte counter, frame end and check residue
// assumes line outputs are registered on mclk
`timescale 1ns/10ps
`default_nettype none
module txco_line_model
   import txco_pkg::*;
(
   input wire logic mclk,
   input wire logic clr,
   input wire logic medium_busy,
   input wire logic [DATA_W-1:0] line_data,
   input wire logic line_valid,
   input wire logic line_end,
   input wire logic coll_timer_start,
   output logic carrier_sense,
   output int nbytes,
   output int coll_at,
   output int end_at,
   output logic [31:0] residue
);
   logic in_frame;
   // reflected crc-32, one input bit at a time
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      crc_step = r;
   endfunction
   // carrier follows the medium
   assign carrier_sense = medium_busy;
   // count line bytes, note timer start and frame end, run crc after the delimiter
   always @(posedge mclk)
   begin
      if (clr)
      begin
         nbytes <= 0;
         coll_at <= -1;
         end_at <= -1;
         in_frame <= 1'b0;
         residue <= CRC_INIT;
      end
      else
      begin
         if (coll_timer_start)
            coll_at <= nbytes;
         if (line_valid)
            nbytes <= nbytes + 1;
         if (line_valid && in_frame)
            residue <= crc_step(residue, line_data);
         if (line_valid && !in_frame && (line_data == SFD_BYTE))
         begin
            in_frame <= 1'b1;
            residue <= CRC_INIT;
         end
         if (line_valid && line_end)
         begin
            end_at <= nbytes + 1;
            in_frame <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// testbench: descriptor options, frame length, deferral, fifo fill
// assumes txco_top, line model and checker are compiled
`timescale 1ns/10ps
`default_nettype none
module tb;
   import txco_pkg::*;
   logic mclk, rst_n, desc_fetch, programmed_tx_interrupt, programmed_tx_interrupt_ack, clr;
   logic late_collision_timer_start, checksum_inhibit, deferral_timer_disable;
   logic [DATA_W-1:0] tx_data, line_data;
   logic tx_last, tx_valid, tx_ready, carrier_sense, medium_busy;
   logic programmed_tx_interrupt_status, excessive_deferral_flag, tx_aborted, coll_timer_start;
   logic line_valid, line_end, busy;
   int nbytes, coll_at, end_at, miscompares = 0, num_checks = 0, cyc = 0;
   logic [31:0] residue;
   txco_top #(.DEFER_LIMIT(20)) dut (
      .mclk(mclk),
      .rst_n(rst_n),
      .desc_fetch(desc_fetch),
      .programmed_tx_interrupt(programmed_tx_interrupt),
      .late_collision_timer_start(late_collision_timer_start),
      .checksum_inhibit(checksum_inhibit),
      .deferral_timer_disable(deferral_timer_disable),
      .programmed_tx_interrupt_ack(programmed_tx_interrupt_ack),
      .tx_data(tx_data),
      .tx_last(tx_last),
      .tx_valid(tx_valid),
      .tx_ready(tx_ready),
      .carrier_sense(carrier_sense),
      .programmed_tx_interrupt_status(programmed_tx_interrupt_status),
      .excessive_deferral_flag(excessive_deferral_flag),
      .tx_aborted(tx_aborted),
      .coll_timer_start(coll_timer_start),
      .line_data(line_data),
      .line_valid(line_valid),
      .line_end(line_end),
      .busy(busy)
   );
   txco_line_model u_line (
      .mclk(mclk),
      .clr(clr),
      .medium_busy(medium_busy),
      .line_data(line_data),
      .line_valid(line_valid),
      .line_end(line_end),
      .coll_timer_start(coll_timer_start),
      .carrier_sense(carrier_sense),
      .nbytes(nbytes),
      .coll_at(coll_at),
      .end_at(end_at),
      .residue(residue)
   );
   // clock
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // hang guard
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         miscompares++;
         complete_run();
      end
   end
   task step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // options: flag, timer start, inhibit, deferral disable
   task fetch(input logic [3:0] opt);
      clr = 1'b1;
      desc_fetch = 1'b1;
      {programmed_tx_interrupt, late_collision_timer_start,
         checksum_inhibit, deferral_timer_disable} = opt;
      step(1);
      desc_fetch = 1'b0;
      clr = 1'b0;
   endtask
   task send(input int n, input logic lst);
      logic ok;
      for (int i = 0; i < n; i++)
      begin
         tx_valid = 1'b1;
         tx_data = i[7:0];
         tx_last = lst && (i == n - 1);
         do
         begin
            ok = tx_ready;
            step(1);
         end
         while (!ok);
      end
      tx_valid = 1'b0;
      tx_last = 1'b0;
   endtask
   task drain();
      for (int k = 0; k < 100 && busy === 1'b1; k++)
         step(1);
      step(4);
   endtask
   task complete_run();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // main sequence
   initial
   begin
      {rst_n, desc_fetch, programmed_tx_interrupt_ack, tx_valid, tx_last, medium_busy, clr} = 7'h00;
      {programmed_tx_interrupt, late_collision_timer_start} = 2'h0;
      {checksum_inhibit, deferral_timer_disable} = 2'h0;
      tx_data = 8'h00;
      step(10);
      rst_n = 1'b1;
      chk(tx_ready, 32'h1, "ready");
      chk(programmed_tx_interrupt_status, 32'h0, "programmed_tx_interrupt");
      fetch(4'hc);
      chk(programmed_tx_interrupt_status, 32'h1, "programmed_tx_interrupt");
      send(5, 1'b1);
      drain();
      chk(nbytes, 32'h11, "bytes");
      chk(end_at, 32'h11, "end");
      chk(residue, 32'hdebb20e3, "fcs");
      chk(coll_at, 32'h0, "coll");
      chk(programmed_tx_interrupt_status, 32'h1, "programmed_tx_interrupt");
      programmed_tx_interrupt_ack = 1'b1;
      step(1);
      programmed_tx_interrupt_ack = 1'b0;
      chk(programmed_tx_interrupt_status, 32'h0, "programmed_tx_interrupt");
      $display("end flagged frame");
      fetch(4'h2);
      send(3, 1'b1);
      drain();
      chk(nbytes, 32'hb, "bytes");
      chk(end_at, 32'hb, "end");
      chk(coll_at, 32'h7, "coll");
      chk(programmed_tx_interrupt_status, 32'h0, "programmed_tx_interrupt");
      $display("end plain frame");
      medium_busy = 1'b1;
      fetch(4'hd);
      send(4, 1'b0);
      chk(tx_ready, 32'h0, "ready");
      step(30);
      chk(excessive_deferral_flag, 32'h1, "exdef");
      chk(tx_aborted, 32'h0, "abort");
      chk(nbytes, 32'h0, "bytes");
      medium_busy = 1'b0;
      send(2, 1'b1);
      drain();
      chk(nbytes, 32'h12, "bytes");
      chk(end_at, 32'h12, "end");
      chk(residue, 32'hdebb20e3, "fcs");
      chk(coll_at, 32'h0, "coll");
      chk(programmed_tx_interrupt_status, 32'h1, "programmed_tx_interrupt");
      $display("end deferred frame");
      medium_busy = 1'b1;
      fetch(4'h0);
      send(3, 1'b1);
      chk(excessive_deferral_flag, 32'h0, "exdef");
      step(30);
      chk(excessive_deferral_flag, 32'h1, "exdef");
      chk(tx_aborted, 32'h1, "abort");
      medium_busy = 1'b0;
      drain();
      chk(nbytes, 32'h0, "bytes");
      chk(end_at, 32'hffffffff, "end");
      chk(tx_ready, 32'h1, "ready");
      $display("end aborted frame");
      complete_run();
   end
endmodule
`default_nettype wire
